/* File: inc/ccp_regs.vh */
// register map, field positions and mode codes of the capture/compare unit
`ifndef CCP_REGS_VH
`define CCP_REGS_VH

`define CCP_CONTROL_OFF      8'h00
`define CCP_COMPARE_LOW_OFF  8'h04
`define CCP_COMPARE_HIGH_OFF 8'h08
`define CCP_STATUS_OFF       8'h0C
`define CCP_MASK_OFF         8'h10
`define CCP_DUTY_OFF         8'h14

`define CCP_CONTROL_RESET    8'h00
`define CCP_CONTROL_WMASK    8'h3F
`define CCP_MODE_LSB         0
`define CCP_MODE_MSB         3
`define CCP_DUTY_LSB         4
`define CCP_DUTY_MSB         5

`define CCP_MODE_OFF         4'h0
`define CCP_MODE_TOGGLE      4'h2
`define CCP_MODE_CAP_FALL    4'h4
`define CCP_MODE_CAP_RISE    4'h5
`define CCP_MODE_CAP_RISE4   4'h6
`define CCP_MODE_CAP_RISE16  4'h7
`define CCP_MODE_SET         4'h8
`define CCP_MODE_CLEAR       4'h9
`define CCP_MODE_SWIRQ       4'hA
`define CCP_MODE_SPECIAL     4'hB

`define CCP_PRESCALE4_LAST   4'h3
`define CCP_PRESCALE16_LAST  4'hF

`define CCP_STAT_IRQ         0
`define CCP_STAT_SPECIAL     1
`define CCP_STAT_WIDTH       2

`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

/* File: rtl/ccp_mode_control.v */
// capture/compare unit: control register, mode decode, capture and compare actions, AXI4-Lite slave
// What this block does
// R1 - control bits 7 and 6 ignore writes and always read as zero.
// R2 - in PWM mode control bits 5:4 form the low two bits of a 10-bit duty whose upper eight come from compare low.
// R3 - mode 0000 turns the unit off and resets its prescaler and compare output latch; status flags and capture value are kept.
// R4 - mode 0010 toggles the compare output and sets the interrupt flag on each timer match.
// R5 - mode 0100 captures on every falling edge of the event pin.
// R6 - mode 0110 captures only on every fourth rising edge.
// R7 - mode 0111 captures only on every sixteenth rising edge using the prescaler.
// R8 - mode 1000 drives the compare output high on match and sets the interrupt flag.
// R9 - mode 1001 drives the compare output low on match and sets the interrupt flag.
// R10 - mode 1010 only sets the interrupt flag on match.
// R11 - mode 1011 issues a special event trigger on match, sets the flag and resets the timer.
// R12 - 0101 captures every rising edge, 0110 every fourth, 1011 is the special event, 0001 and 0011 act as off.
// R13 - a capture copies the 16-bit timer into the capture registers, overwriting any unread value.
// R14 - each capture sets the interrupt flag, which only software clears.
// R15 - the prescaler clears when off, outside capture modes and on reset, but not between prescale settings.
// R16 - the special event clears the timer without its overflow flag and starts an ADC conversion.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_regs.vh"

module ccp_mode_control (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] timer_value,
	input  wire        event_pin,
	output reg         compare_out,
	output reg         timer_clear,
	output reg         adc_start,
	output reg  [9:0]  pwm_duty,
	output reg         irq
);

	////////////////////////////////////////////////////////////////////////
	function is_capture;
		input [3:0] m;
		begin
			is_capture = (m == `CCP_MODE_CAP_FALL) || (m == `CCP_MODE_CAP_RISE) ||
			             (m == `CCP_MODE_CAP_RISE4) || (m == `CCP_MODE_CAP_RISE16);
		end
	endfunction

	function is_compare;
		input [3:0] m;
		begin
			is_compare = (m == `CCP_MODE_TOGGLE) || (m[3] && (m[2:0] <= 3'h3));
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	reg  [5:0]  control_q;
	reg  [7:0]  compare_value_low;
	reg  [7:0]  compare_value_high;
	reg  [`CCP_STAT_WIDTH-1:0] status_q;
	reg  [`CCP_STAT_WIDTH-1:0] mask_q;
	reg  [15:0] capture_q;
	reg  [3:0]  prescale_q;
	reg         pin_q;
	reg         match_q;
	reg         aw_hold_q;
	reg         w_hold_q;
	reg  [7:0]  aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;

	wire [3:0]  unit_mode_field = control_q[`CCP_MODE_MSB:`CCP_MODE_LSB];
	wire        mode_off = !is_capture(unit_mode_field) && !is_compare(unit_mode_field) &&
	                       (unit_mode_field[3:2] == 2'h0);
	wire [15:0] compare_value = {compare_value_high, compare_value_low};

	// compare fires once on entry to a match, not every cycle the timer sits there
	wire        match_now = (timer_value == compare_value);
	wire        match_evt = match_now && !match_q && is_compare(unit_mode_field);
	wire        rise = event_pin && !pin_q;
	wire        fall = !event_pin && pin_q;

	reg         edge_evt;
	reg         cap_evt;
	always @* begin
		edge_evt = 1'b0;
		cap_evt = 1'b0;
		case (unit_mode_field)
			`CCP_MODE_CAP_FALL: begin
				cap_evt = fall; // see R5
			end
			`CCP_MODE_CAP_RISE: begin
				cap_evt = rise; // see R12
			end
			`CCP_MODE_CAP_RISE4: begin
				edge_evt = rise;
				cap_evt = rise && (prescale_q[1:0] == `CCP_PRESCALE4_LAST); // see R6
			end
			`CCP_MODE_CAP_RISE16: begin
				edge_evt = rise;
				cap_evt = rise && (prescale_q == `CCP_PRESCALE16_LAST); // see R7
			end
			default: begin
				edge_evt = 1'b0;
				cap_evt = 1'b0;
			end
		endcase
	end

	wire        special_evt = match_evt && (unit_mode_field == `CCP_MODE_SPECIAL);
	wire        irq_evt = match_evt || cap_evt;

	////////////////////////////////////////////////////////////////////////
	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'h0) && (a <= `CCP_DUTY_OFF);
		end
	endfunction

	function hits;
		input [7:0] a;
		input [7:0] slot;
		begin
			hits = (a[7:2] == slot[7:2]);
		end
	endfunction

	wire        do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	// refused writes (unmapped, unaligned, lane 0 off) still answer but change nothing
	wire        do_store = do_write && mapped(aw_addr_q) && w_strb_q[0];
	wire        wr_ctrl  = do_store && hits(aw_addr_q, `CCP_CONTROL_OFF);
	wire        wr_cmpl  = do_store && hits(aw_addr_q, `CCP_COMPARE_LOW_OFF);
	wire        wr_cmph  = do_store && hits(aw_addr_q, `CCP_COMPARE_HIGH_OFF);
	wire        wr_stat  = do_store && hits(aw_addr_q, `CCP_STATUS_OFF);
	wire        wr_mask  = do_store && hits(aw_addr_q, `CCP_MASK_OFF);
	wire [7:0]  ctrl_wr  = w_data_q[7:0] & `CCP_CONTROL_WMASK;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_RESP_OKAY;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr_q) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				case (s_axi_araddr)
					`CCP_CONTROL_OFF: s_axi_rdata <= {26'h0000000, control_q}; // see R1
					`CCP_COMPARE_LOW_OFF: s_axi_rdata <= {24'h000000, compare_value_low};
					`CCP_COMPARE_HIGH_OFF: s_axi_rdata <= {24'h000000, compare_value_high};
					`CCP_STATUS_OFF: s_axi_rdata <= {30'h00000000, status_q};
					`CCP_MASK_OFF: s_axi_rdata <= {30'h00000000, mask_q};
					`CCP_DUTY_OFF: s_axi_rdata <= {16'h0000, capture_q};
					default: s_axi_rdata <= 32'h00000000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (!aresetn) begin
			control_q <= 6'h00;
			compare_value_low <= 8'h00;
			compare_value_high <= 8'h00;
			mask_q <= {`CCP_STAT_WIDTH{1'b0}};
		end else begin
			if (wr_ctrl)
				control_q <= ctrl_wr[5:0]; // see R1
			if (wr_cmpl)
				compare_value_low <= w_data_q[7:0];
			if (wr_cmph)
				compare_value_high <= w_data_q[7:0];
			if (wr_mask)
				mask_q <= w_data_q[`CCP_STAT_WIDTH-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin and match history follow their inputs in every mode
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= 1'b0;
			match_q <= 1'b0;
		end else begin
			pin_q <= event_pin;
			match_q <= match_now;
		end
	end

	// kept across 4th/16th changes, so a switch without an off may capture early
	always @(posedge aclk) begin
		if (!aresetn) begin
			prescale_q <= 4'h0; // see R15
		end else if (!is_capture(unit_mode_field)) begin
			prescale_q <= 4'h0; // see R15
		end else if (edge_evt) begin
			prescale_q <= prescale_q + 4'h1; // see R7
		end
	end

	// capture value reads at the duty slot; a newer capture overwrites an unread one
	always @(posedge aclk) begin
		if (!aresetn) begin
			capture_q <= 16'h0000;
		end else if (cap_evt) begin
			capture_q <= timer_value; // see R13
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			compare_out <= 1'b0;
		end else if (mode_off) begin
			compare_out <= 1'b0; // see R3 R12
		end else if (match_evt) begin
			case (unit_mode_field)
				`CCP_MODE_TOGGLE: compare_out <= !compare_out; // see R4
				`CCP_MODE_SET: compare_out <= 1'b1; // see R8
				`CCP_MODE_CLEAR: compare_out <= 1'b0; // see R9
				default: compare_out <= compare_out; // see R10
			endcase
		end
	end

	// duty assembly only; the PWM datapath is outside this block
	always @(posedge aclk) begin
		if (!aresetn) begin
			pwm_duty <= 10'h000;
		end else begin
			pwm_duty <= {compare_value_low, control_q[`CCP_DUTY_MSB:`CCP_DUTY_LSB]}; // see R2
		end
	end

	// timer clear and converter start leave together as one-cycle pulses
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_clear <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			timer_clear <= special_evt; // see R11
			adc_start <= special_evt; // see R16
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire [`CCP_STAT_WIDTH-1:0] status_set;
	assign status_set[`CCP_STAT_IRQ] = irq_evt; // see R14
	assign status_set[`CCP_STAT_SPECIAL] = special_evt; // see R11

	genvar gi;
	generate
		for (gi = 0; gi < `CCP_STAT_WIDTH; gi = gi + 1) begin : g_status
			// set wins over a write-one-clear in the same cycle, so no event is lost
			always @(posedge aclk) begin
				if (!aresetn) begin
					status_q[gi] <= 1'b0;
				end else begin
					status_q[gi] <= status_set[gi] || (status_q[gi] && !(wr_stat && w_data_q[gi])); // see R14
				end
			end
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

endmodule
`default_nettype wire

/* File: tb/ccp_checker.sv */
// port assertions for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module ccp_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic compare_out,
	input wire logic timer_clear,
	input wire logic adc_start,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pair; (timer_clear || adc_start) |-> (timer_clear && adc_start); endproperty
	a_pair: assert property (p_pair) else $error("clear and start apart");
	property p_pulse; timer_clear |=> !timer_clear; endproperty
	a_pulse: assert property (p_pulse) else $error("clear too long");
	property p_rst; $rose(aresetn) |-> !compare_out && !irq && !timer_clear; endproperty
	a_rst: assert property (p_rst) else $error("dirty reset");
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("late read data");
	property p_bans; $rose(s_axi_bvalid) |-> $past(s_axi_awready, 2); endproperty
	a_bans: assert property (p_bans) else $error("early response");
	property p_arp; s_axi_arready |=> !s_axi_arready; endproperty
	a_arp: assert property (p_arp) else $error("arready stuck");
	property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdrop: assert property (p_bdrop) else $error("bvalid stuck");
	property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdrop: assert property (p_rdrop) else $error("rvalid stuck");
endmodule
bind ccp_mode_control ccp_checker u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .compare_out, .timer_clear, .adc_start, .irq);
`default_nettype wire

/* File: tb/timer_model.sv */
// free-running 16-bit timer beside the unit
`timescale 1ns/1ps
`default_nettype none
module timer_model (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        timer_clear,
	output var logic [15:0] timer_value
);
	always @(posedge aclk) begin
		if (!aresetn || timer_clear) begin
			timer_value <= 16'h0000;
		end else begin
			timer_value <= timer_value + 16'h0001;
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`include "ccp_regs.vh"
module testbench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, event_pin, e;
	logic [7:0] s_axi_awaddr, s_axi_araddr, c, cl;
	logic [31:0] s_axi_wdata, rd;
	logic [3:0] s_axi_wstrb, m;
	logic [15:0] t0;
	logic [1:0] rr, br;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic compare_out, timer_clear, adc_start, irq;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [15:0] timer_value;
	wire logic [9:0] pwm_duty;
	int err_count, compares, clears;
	int kn [4] = '{1, 1, 4, 16};
	logic [3:0] km [4] = '{`CCP_MODE_CAP_FALL, `CCP_MODE_CAP_RISE, `CCP_MODE_CAP_RISE4, `CCP_MODE_CAP_RISE16};
	logic [3:0] cm [5] = '{`CCP_MODE_SET, `CCP_MODE_CLEAR, `CCP_MODE_TOGGLE, `CCP_MODE_SWIRQ, `CCP_MODE_SPECIAL};
	ccp_mode_control DUT (.*);
	timer_model u_timer (.*);
	task automatic ck(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		br = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic pulse();
		event_pin <= 1'h1;
		repeat (1 + $urandom % 3) @(posedge aclk);
		event_pin <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask
	function automatic logic xo(input logic [3:0] k, input logic p);
		case (k)
			`CCP_MODE_TOGGLE: return !p;
			`CCP_MODE_SET: return 1'h1;
			`CCP_MODE_CLEAR: return 1'h0;
			default: return p;
		endcase
	endfunction
	task automatic wrap_up();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'h0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) if (timer_clear && adc_start) clears++;
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		wrap_up();
	end
	initial begin
		aresetn = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, event_pin} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h000000000000;
		s_axi_wstrb = 4'hF;
		void'($urandom(32'h8C74AAAA));
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rdr(`CCP_CONTROL_OFF);
		ck(rd, `CCP_CONTROL_RESET);
		repeat (4) begin
			// modes 8-F stay out here: a stray special event would clear the timer
			c = 8'($urandom) & 8'hF7;
			cl = 8'($urandom);
			wr(`CCP_CONTROL_OFF, c);
			wr(`CCP_COMPARE_LOW_OFF, cl);
			ck(br, `AXI_RESP_OKAY);
			rdr(`CCP_CONTROL_OFF);
			ck(rd, {24'h000000, c & `CCP_CONTROL_WMASK});
			ck(pwm_duty, {cl, c[5:4]});
		end
		rdr(8'h18);
		ck(rr, `AXI_RESP_SLVERR);
		wr(8'h01, 8'hFF);
		ck(br, `AXI_RESP_SLVERR);
		rdr(`CCP_CONTROL_OFF);
		ck(rd, {24'h000000, c & `CCP_CONTROL_WMASK});
		$display("register test done");
		wr(`CCP_MASK_OFF, 8'h01);
		e = 1'h0;
		foreach (cm[i]) begin
			m = cm[i];
			// no off before clear mode, so the latch enters it high
			// odd passes use reserved code 0011, which must force the latch low like 0000
			if (m != `CCP_MODE_CLEAR) begin
				wr(`CCP_CONTROL_OFF, 8'((i % 2) * 3));
				e = 1'h0;
			end
			wr(`CCP_STATUS_OFF, 8'h03);
			t0 = timer_value + 16'h003C;
			wr(`CCP_COMPARE_LOW_OFF, t0[7:0]);
			wr(`CCP_COMPARE_HIGH_OFF, t0[15:8]);
			c = 8'($urandom);
			wr(`CCP_CONTROL_OFF, {2'h0, c[5:4], m});
			e = xo(m, e);
			while (irq !== 1'h1) begin
				@(posedge aclk);
			end
			ck(compare_out, e);
			rdr(`CCP_STATUS_OFF);
			ck(rd, m == `CCP_MODE_SPECIAL ? 3 : 1);
		end
		ck(clears, 1);
		$display("compare test done");
		foreach (km[i]) begin
			wr(`CCP_CONTROL_OFF, 8'h00);
			wr(`CCP_STATUS_OFF, 8'h03);
			wr(`CCP_CONTROL_OFF, {4'h0, km[i]});
			repeat (kn[i] - 1) pulse();
			rdr(`CCP_STATUS_OFF);
			ck(rd, 0);
			t0 = timer_value;
			pulse();
			rdr(`CCP_DUTY_OFF);
			ck(rd[15:0] - t0 < 16'h0008, 1);
			rdr(`CCP_STATUS_OFF);
			ck(rd, 1);
		end
		$display("capture test done");
		wrap_up();
	end
endmodule
`default_nettype wire
